// ===== include/htm_pkg.sv
// Purpose: constants and types of the humidity/temperature sensor host controller
// Assumes: 40 MHz pclk, APB register port, sensor reached over open-drain I2C
// Notes: byte addresses are word aligned; all counts derive from printed times
// ----------------------------------------------------------------------------
// Function
// - wait at least 1 ms after one command before sending the next
// - commands are 16-bit words that already hold 3 check bits
// - every 16-bit data word travels followed by its 8-bit CRC byte
// - written data carries a trailing CRC; bad CRC makes the sensor drop it
// - checking CRC bytes on reads is optional for the host
// - measurement starts with START, write header (address, bit 0), 16-bit command
// - single-shot commands: 0x2C06/0D/10 stretching, 0x2400/0B/16 without
// - host ends full readout with NACK and STOP, or NACKs early
// - host ignoring CRC still reads temperature CRC, both humidity bytes
// - break command aborts measurement, returns to single shot; send when busy
// - address select level holds from START to end of transfer
// ----------------------------------------------------------------------------
package htm_pkg;

  // ----------------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned SCL_KHZ = 400;
  localparam int unsigned QUARTER_CYC = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
  localparam logic [6:0] DIV_MAX = 7'(QUARTER_CYC - 1);
  localparam int unsigned CMD_GAP_US = 1000;
  localparam int unsigned CMD_GAP_CYC = (CMD_GAP_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned PU_DELAY_US = 1000;
  localparam int unsigned PU_DELAY_CYC = (PU_DELAY_US * CLK_KHZ + 999) / 1000;

  // ----------------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CMD = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_RES = 12'h00C;
  localparam logic [11:0] OFF_CRC = 12'h010;

  localparam int CTRL_GO = 0;
  localparam int CTRL_OP = 1;
  localparam int CTRL_WDATA = 2;
  localparam int CTRL_CRCEN = 3;
  localparam int CTRL_ADDR = 8;
  localparam int CTRL_LEN = 16;

  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_NACK = 2;
  localparam int STAT_TERR = 3;
  localparam int STAT_HERR = 4;
  localparam int STAT_READY = 5;
  localparam int STAT_NRX = 8;

  localparam int CMD_WORD = 0;
  localparam int CMD_DATA = 16;
  localparam int CRC_POLY = 0;
  localparam int CRC_INIT = 8;

  localparam logic [6:0] RST_DEV_ADDR = 7'h44;
  localparam logic [2:0] RST_RD_LEN = 3'h6;
  localparam logic [2:0] RD_LEN_MIN = 3'h1;
  localparam logic [7:0] RST_CRC_POLY = 8'h07;
  localparam logic [7:0] RST_CRC_INIT = 8'h00;

  // ----------------------------------------------------------------------------
  // byte slots of a transfer
  // ----------------------------------------------------------------------------
  localparam logic [2:0] B_HDR = 3'h0;
  localparam logic [2:0] B_CMD_HI = 3'h1;
  localparam logic [2:0] B_CMD_LO = 3'h2;
  localparam logic [2:0] B_DAT_HI = 3'h3;
  localparam logic [2:0] B_DAT_LO = 3'h4;
  localparam logic [2:0] B_DAT_CRC = 3'h5;
  localparam logic [2:0] B_T_HI = 3'h1;
  localparam logic [2:0] B_T_LO = 3'h2;
  localparam logic [2:0] B_T_CRC = 3'h3;
  localparam logic [2:0] B_H_HI = 3'h4;
  localparam logic [2:0] B_H_LO = 3'h5;
  localparam logic [2:0] B_H_CRC = 3'h6;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // single-shot commands, for software to place in the command register
  localparam logic [15:0] CMD_SS_STR_HIGH = 16'h2C06;
  localparam logic [15:0] CMD_SS_STR_MED = 16'h2C0D;
  localparam logic [15:0] CMD_SS_STR_LOW = 16'h2C10;
  localparam logic [15:0] CMD_SS_NOSTR_HIGH = 16'h2400;
  localparam logic [15:0] CMD_SS_NOSTR_MED = 16'h240B;
  localparam logic [15:0] CMD_SS_NOSTR_LOW = 16'h2416;

  typedef enum logic [2:0] {
    ST_PWR,
    ST_IDLE,
    ST_GAP,
    ST_START,
    ST_BYTE,
    ST_STOP
  } htm_state_t;

endpackage

// ===== src/htm_crc8.sv
// Purpose: one-byte step of an msb-first crc-8
// Assumes: polynomial given without its top bit
// Notes: purely combinational; the caller holds the running value
`timescale 1ns/1ps
module htm_crc8 (
  input wire logic [7:0] poly,
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data,
  output logic [7:0] crc_out
);
  import htm_pkg::*;

  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ poly) : {c[6:0], 1'b0};
    end
    crc_out = c;
  end
endmodule

// ===== src/htm_i2c_host.sv
// Purpose: i2c host that sends commands to the sensor and reads its results
// Assumes: apb slave with zero wait states; scl and sda are open-drain pins
// Notes: software writes the command word itself, break and periodic included
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module htm_i2c_host #(
  parameter int unsigned CMD_GAP_CYCLES = htm_pkg::CMD_GAP_CYC,
  parameter int unsigned PU_DELAY_CYCLES = htm_pkg::PU_DELAY_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import htm_pkg::*;

  localparam logic [19:0] GAP_LD = 20'(CMD_GAP_CYCLES);
  localparam logic [19:0] PU_LD = 20'(PU_DELAY_CYCLES);

  typedef struct packed {
    htm_state_t st;
    logic [1:0] ph;
    logic [6:0] div;
    logic [19:0] tmr;
    logic pu_done;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic scl_oe;
    logic sda_oe;
    logic [7:0] sh;
    logic [3:0] bitn;
    logic [2:0] idx;
    logic ackb;
    logic op;
    logic wdat_en;
    logic crc_en;
    logic [6:0] dev_addr;
    logic [2:0] rd_len;
    logic [15:0] cmd;
    logic [15:0] wdat;
    logic [7:0] poly;
    logic [7:0] init;
    logic [7:0] crc;
    logic done;
    logic nack;
    logic t_err;
    logic h_err;
    logic [15:0] temp;
    logic [15:0] hum;
    logic [2:0] nrx;
  } htm_host_t;

  htm_host_t q;
  htm_host_t d;
  logic [7:0] crc_nxt;

  // ----------------------------------------------------------------------------
  // crc of the byte just moved
  // ----------------------------------------------------------------------------
  htm_crc8 u_crc (
    .poly(q.poly),
    .crc_in(q.crc),
    .data(q.sh),
    .crc_out(crc_nxt)
  );

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    logic tick;
    logic wr;
    logic rd_byte;
    logic [2:0] last_w;
    logic [2:0] len_w;
    logic [7:0] nxt_w;
    d = q;
    tick = (q.div == DIV_MAX);
    wr = psel & penable & pwrite;
    rd_byte = q.op && (q.idx != B_HDR);
    last_w = q.wdat_en ? B_DAT_CRC : B_CMD_LO;
    len_w = pwdata[CTRL_LEN +: 3];
    if (len_w < RD_LEN_MIN) begin
      len_w = RD_LEN_MIN;
    end else if (len_w > RST_RD_LEN) begin
      len_w = RST_RD_LEN;
    end
    case (q.idx)
      B_HDR: nxt_w = q.cmd[15:8];
      B_CMD_HI: nxt_w = q.cmd[7:0];
      B_CMD_LO: nxt_w = q.wdat[15:8];
      B_DAT_HI: nxt_w = q.wdat[7:0];
      default: nxt_w = crc_nxt;
    endcase

    // one quarter of an scl period per tick keeps the bus at the set rate
    d.div = tick ? 7'h00 : q.div + 7'h01;
    d.scl_s1 = scl_i;
    d.scl_s2 = q.scl_s1;
    d.sda_s1 = sda_i;
    d.sda_s2 = q.sda_s1;
    if (q.tmr != 20'h00000) begin
      d.tmr = q.tmr - 20'h00001;
    end

    // ----------------------------------------------------------------------------
    // register writes; hardware sets below win over these clears
    // ----------------------------------------------------------------------------
    if (wr && paddr == OFF_STAT) begin
      if (pwdata[STAT_DONE]) d.done = 1'b0;
      if (pwdata[STAT_NACK]) d.nack = 1'b0;
      if (pwdata[STAT_TERR]) d.t_err = 1'b0;
      if (pwdata[STAT_HERR]) d.h_err = 1'b0;
    end
    if (wr && q.st == ST_IDLE) begin
      if (paddr == OFF_CMD) begin
        d.cmd = pwdata[CMD_WORD +: 16];
        d.wdat = pwdata[CMD_DATA +: 16];
      end
      if (paddr == OFF_CRC) begin
        d.poly = pwdata[CRC_POLY +: 8];
        d.init = pwdata[CRC_INIT +: 8];
      end
      if (paddr == OFF_CTRL) begin
        d.op = pwdata[CTRL_OP];
        d.wdat_en = pwdata[CTRL_WDATA];
        d.crc_en = pwdata[CTRL_CRCEN];
        d.dev_addr = pwdata[CTRL_ADDR +: 7];
        d.rd_len = len_w;
        if (pwdata[CTRL_GO]) begin
          // address is frozen in the header for the whole transfer
          d.sh = {pwdata[CTRL_ADDR +: 7], pwdata[CTRL_OP]};
          d.idx = B_HDR;
          d.bitn = 4'h0;
          d.ph = 2'h0;
          d.crc = q.init;
          d.nrx = 3'h0;
          d.st = (!pwdata[CTRL_OP] && q.tmr != 20'h00000) ? ST_GAP : ST_START;
        end
      end
    end

    // ----------------------------------------------------------------------------
    // transfer engine
    // ----------------------------------------------------------------------------
    case (q.st)
      ST_PWR: begin
        if (q.tmr == 20'h00000) begin
          d.pu_done = 1'b1;
          d.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
      end
      ST_GAP: begin
        if (q.tmr == 20'h00000) begin
          d.st = ST_START;
        end
      end
      ST_START: begin
        if (tick) begin
          if (q.ph == 2'h0) begin
            if (q.scl_s2 && q.sda_s2) begin
              d.sda_oe = 1'b1;
              d.ph = 2'h1;
            end
          end else begin
            d.scl_oe = 1'b1;
            d.ph = 2'h0;
            d.st = ST_BYTE;
          end
        end
      end
      ST_BYTE: begin
        if (tick) begin
          case (q.ph)
            2'h0: begin
              if (q.bitn < ACK_BIT) begin
                d.sda_oe = rd_byte ? 1'b0 : ~q.sh[7];
              end else begin
                d.sda_oe = rd_byte && (q.idx != q.rd_len);
              end
              d.ph = 2'h1;
            end
            2'h1: begin
              d.scl_oe = 1'b0;
              d.ph = 2'h2;
            end
            2'h2: begin
              // a sensor holding scl low stalls the bit here
              if (q.scl_s2) begin
                if (q.bitn < ACK_BIT) begin
                  d.sh = {q.sh[6:0], q.sda_s2};
                end else begin
                  d.ackb = q.sda_s2;
                end
                d.ph = 2'h3;
              end
            end
            2'h3: begin
              d.scl_oe = 1'b1;
              d.ph = 2'h0;
              if (q.bitn < ACK_BIT) begin
                d.bitn = q.bitn + 4'h1;
              end else begin
                d.bitn = 4'h0;
                d.idx = q.idx + 3'h1;
                if (!rd_byte) begin
                  if (q.ackb) begin
                    d.nack = 1'b1;
                    d.st = ST_STOP;
                  end else if (q.op) begin
                    d.sh = 8'h00;
                  end else if (q.idx == last_w) begin
                    d.st = ST_STOP;
                  end else begin
                    d.sh = nxt_w;
                    if (q.idx == B_DAT_HI || q.idx == B_DAT_LO) begin
                      d.crc = crc_nxt;
                    end
                  end
                end else begin
                  d.nrx = q.idx;
                  case (q.idx)
                    B_T_HI: d.temp[15:8] = q.sh;
                    B_T_LO: d.temp[7:0] = q.sh;
                    B_H_HI: d.hum[15:8] = q.sh;
                    B_H_LO: d.hum[7:0] = q.sh;
                    default: begin
                    end
                  endcase
                  if (q.idx == B_T_CRC || q.idx == B_H_CRC) begin
                    d.crc = q.init;
                    if (q.crc_en && q.crc != q.sh) begin
                      if (q.idx == B_T_CRC) d.t_err = 1'b1;
                      else d.h_err = 1'b1;
                    end
                  end else begin
                    d.crc = crc_nxt;
                  end
                  if (q.idx == q.rd_len) begin
                    d.st = ST_STOP;
                  end
                end
              end
            end
            default: d.ph = 2'h0;
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          case (q.ph)
            2'h0: begin
              d.sda_oe = 1'b1;
              d.ph = 2'h1;
            end
            2'h1: begin
              d.scl_oe = 1'b0;
              d.ph = 2'h2;
            end
            2'h2: begin
              if (q.scl_s2) d.ph = 2'h3;
            end
            default: begin
              d.sda_oe = 1'b0;
              d.ph = 2'h0;
              d.done = 1'b1;
              d.st = ST_IDLE;
              if (!q.op) d.tmr = GAP_LD;
            end
          endcase
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= ST_PWR;
      q.tmr <= PU_LD;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.dev_addr <= RST_DEV_ADDR;
      q.rd_len <= RST_RD_LEN;
      q.poly <= RST_CRC_POLY;
      q.init <= RST_CRC_INIT;
      q.crc <= RST_CRC_INIT;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------------
  // apb read side and pins
  // ----------------------------------------------------------------------------
  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    case (paddr)
      OFF_CTRL: begin
        prdata[CTRL_OP] = q.op;
        prdata[CTRL_WDATA] = q.wdat_en;
        prdata[CTRL_CRCEN] = q.crc_en;
        prdata[CTRL_ADDR +: 7] = q.dev_addr;
        prdata[CTRL_LEN +: 3] = q.rd_len;
      end
      OFF_CMD: prdata = {q.wdat, q.cmd};
      OFF_STAT: begin
        prdata[STAT_BUSY] = (q.st != ST_IDLE);
        prdata[STAT_DONE] = q.done;
        prdata[STAT_NACK] = q.nack;
        prdata[STAT_TERR] = q.t_err;
        prdata[STAT_HERR] = q.h_err;
        prdata[STAT_READY] = q.pu_done;
        prdata[STAT_NRX +: 3] = q.nrx;
      end
      OFF_RES: prdata = {q.hum, q.temp};
      OFF_CRC: prdata[15:0] = {q.init, q.poly};
      default: pslverr = psel & penable;
    endcase
  end

  assign pready = 1'b1;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  property p_div_bound;
    @(posedge pclk) disable iff (!presetn) q.div == DIV_MAX |=> q.div == 7'h00;
  endproperty
  a_div_bound: assert property (p_div_bound) else $error("divider overran");

  property p_gap;
    @(posedge pclk) disable iff (!presetn) (q.st == ST_START && !q.op) |-> q.tmr == 20'h00000;
  endproperty
  a_gap: assert property (p_gap) else $error("command sent inside gap");

  property p_hdr_dir;
    @(posedge pclk) disable iff (!presetn)
      (q.st == ST_BYTE && q.idx == B_HDR && q.bitn == 4'h7 && q.ph == 2'h2) |-> q.sda_oe == !q.op;
  endproperty
  a_hdr_dir: assert property (p_hdr_dir) else $error("header direction bit wrong");

  property p_last_nack;
    @(posedge pclk) disable iff (!presetn)
      (q.st == ST_BYTE && q.op && q.idx == q.rd_len && q.bitn == ACK_BIT && q.ph == 2'h2)
      |-> !q.sda_oe;
  endproperty
  a_last_nack: assert property (p_last_nack) else $error("last byte acknowledged");

  property p_mid_ack;
    @(posedge pclk) disable iff (!presetn)
      (q.st == ST_BYTE && q.op && q.idx != B_HDR && q.idx != q.rd_len
       && q.bitn == ACK_BIT && q.ph == 2'h2) |-> q.sda_oe;
  endproperty
  a_mid_ack: assert property (p_mid_ack) else $error("middle byte not acknowledged");

  property p_hdr_nack_stop;
    @(posedge pclk) disable iff (!presetn)
      (q.st == ST_BYTE && q.idx == B_HDR && q.bitn == ACK_BIT && q.ph == 2'h3
       && q.ackb && q.div == DIV_MAX) |=> (q.st == ST_STOP && q.nack);
  endproperty
  a_hdr_nack_stop: assert property (p_hdr_nack_stop) else $error("nack not ending transfer");

  property p_stretch;
    @(posedge pclk) disable iff (!presetn)
      (q.st == ST_BYTE && q.ph == 2'h2 && !q.scl_s2) |=> (q.ph == 2'h2 && !q.scl_oe);
  endproperty
  a_stretch: assert property (p_stretch) else $error("bit advanced while scl held");

  property p_crc_byte;
    @(posedge pclk) disable iff (!presetn)
      (q.st == ST_BYTE && !q.op && q.idx == B_DAT_CRC && q.bitn == 4'h0 && q.ph == 2'h0)
      |-> q.sh == q.crc;
  endproperty
  a_crc_byte: assert property (p_crc_byte) else $error("crc byte mismatch");

  property p_pu;
    @(posedge pclk) disable iff (!presetn) (q.st != ST_PWR) |-> q.pu_done;
  endproperty
  a_pu: assert property (p_pu) else $error("traffic before power-up delay");
endmodule

// ===== tb/htm_sensor_model.sv
// Purpose: behavioural sensor seen from its i2c pins
// Assumes: open-drain lines resolved with pull-ups by the bench
// Notes: single-shot and data-word commands only; periodic and break are left out
`timescale 1ns/1ps
module htm_sensor_model #(
  parameter logic [6:0] ADDR = 7'h44,
  parameter logic [7:0] POLY = 8'h31,
  parameter logic [7:0] INIT = 8'hFF,
  parameter logic [15:0] TEMP = 16'h6A5C,
  parameter logic [15:0] HUM = 16'h8E13,
  parameter int MEAS_NS = 150000,
  parameter int PU_NS = 2000,
  parameter int GAP_NS = 4975
) (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  import htm_pkg::*;
  logic [15:0] last_cmd = 16'h0000;
  logic [15:0] last_data = 16'h0000;
  logic [7:0] k;
  logic gap_err = 1'b0;
  logic pend = 1'b0;
  logic strch = 1'b0;
  logic wr = 1'b0;
  logic mack;
  logic [7:0] b;
  logic [7:0] c;
  logic [47:0] res;
  time t_end = 0;
  time t_stop = 0;
  time t_go;
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] r;
    r = INIT;
    for (int i = 15; i >= 0; i--) begin
      r = {r[6:0], 1'b0} ^ ((r[7] ^ w[i]) ? POLY : 8'h00);
    end
    return r;
  endfunction
  task automatic rx(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      v = {v[6:0], sda};
    end
    @(negedge scl);
  endtask
  task automatic ack();
    sda_oe = 1'b1;
    @(negedge scl);
    sda_oe = 1'b0;
  endtask
  task automatic tx(input logic [7:0] v, output logic a);
    for (int i = 7; i >= 0; i--) begin
      sda_oe = ~v[i];
      @(negedge scl);
    end
    sda_oe = 1'b0;
    @(posedge scl);
    a = ~sda;
    @(negedge scl);
  endtask
  // stop of a write transfer starts the command spacing
  always @(posedge sda) begin
    if (scl === 1'b1 && wr) begin
      t_stop = $time;
    end
  end
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    forever begin
      @(negedge sda iff scl === 1'b1);
      t_go = $time;
      @(negedge scl);
      rx(b);
      wr = ~b[0];
      if (b[7:1] === ADDR && $time >= PU_NS && wr) begin
        if (t_go - t_stop < GAP_NS) begin
          gap_err = 1'b1;
        end
        ack();
        rx(b);
        ack();
        rx(c);
        last_cmd = {b, c};
        if ({b, c} inside {CMD_SS_STR_HIGH, CMD_SS_STR_MED, CMD_SS_STR_LOW,
            CMD_SS_NOSTR_HIGH, CMD_SS_NOSTR_MED, CMD_SS_NOSTR_LOW}) begin
          pend = 1'b1;
          strch = (b == 8'h2C);
          t_end = $time + MEAS_NS;
          ack();
        end else begin
          // any other command is taken as one that carries a data word
          ack();
          rx(b);
          ack();
          rx(c);
          ack();
          rx(k);
          if (k == crc8({b, c})) begin
            last_data = {b, c};
            ack();
          end
        end
      end else if (b[7:1] === ADDR && pend && (strch || $time >= t_end)) begin
        pend = 1'b0;
        res = {TEMP ^ last_cmd, crc8(TEMP ^ last_cmd), HUM, crc8(HUM)};
        ack();
        sda_oe = ~res[47];
        if ($time < t_end) begin
          scl_oe = 1'b1;
          #(t_end - $time);
          scl_oe = 1'b0;
        end
        mack = 1'b1;
        for (int k = 0; k < 6 && mack; k++) begin
          tx(res[47 - 8 * k -: 8], mack);
        end
        sda_oe = 1'b0;
      end
    end
  end
endmodule

// ===== tb/humidity_temp_i2c_measure_ctrl_tb_top.sv
// Purpose: self-checking bench of the sensor host controller
// Assumes: sensor model on the wired-and i2c lines
// Notes: power-up wait and command gap shortened to 200 cycles
`timescale 1ns/1ps
module humidity_temp_i2c_measure_ctrl_tb_top;
  import htm_pkg::*;
  localparam int unsigned PU = 200;
  localparam int unsigned GAP = 200;
  localparam int MEAS = 150000;
  localparam logic [7:0] POLY = 8'h31;
  localparam logic [7:0] INIT = 8'hFF;
  localparam logic [15:0] TEMP = 16'h6A5C;
  localparam logic [15:0] HUM = 16'h8E13;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic scl_oe;
  logic sda_oe;
  logic m_scl_oe;
  logic m_sda_oe;
  wire scl = ~(scl_oe | m_scl_oe);
  wire sda = ~(sda_oe | m_sda_oe);
  logic [31:0] r;
  logic [31:0] s;
  logic serr;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  logic [15:0] cmds [6] = '{CMD_SS_STR_HIGH, CMD_SS_STR_MED, CMD_SS_STR_LOW,
    CMD_SS_NOSTR_HIGH, CMD_SS_NOSTR_MED, CMD_SS_NOSTR_LOW};
  htm_i2c_host #(.CMD_GAP_CYCLES(GAP), .PU_DELAY_CYCLES(PU)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  htm_sensor_model #(.POLY(POLY), .INIT(INIT), .TEMP(TEMP), .HUM(HUM), .MEAS_NS(MEAS),
    .GAP_NS((GAP - 1) * 25)) sensor (
    .scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  always #12.5 pclk = ~pclk;
  task automatic stop_test();
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ceiling sits well above the ~45k cycles that the whole run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] ctl(input logic op, input logic [2:0] len);
    return {13'h0, len, 1'b0, RST_DEV_ADDR, 4'h0, op, 1'b0, op, 1'b1};
  endfunction
  // go, poll busy, keep the status, then clear the sticky flags
  task automatic run(input logic [31:0] c);
    bus(1'b1, OFF_CTRL, c);
    bus(1'b0, OFF_STAT, 32'h0);
    while (r[STAT_BUSY] !== 1'b0) bus(1'b0, OFF_STAT, 32'h0);
    s = r;
    bus(1'b1, OFF_STAT, 32'h0000_001E);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl reset", r, {13'h0, RST_RD_LEN, 1'b0, RST_DEV_ADDR, 8'h00});
    bus(1'b0, OFF_CRC, 32'h0);
    chk("crc reset", r, {16'h0, RST_CRC_INIT, RST_CRC_POLY});
    bus(1'b0, OFF_STAT, 32'h0);
    chk("ready early", 32'(r[STAT_READY]), 32'h0);
    bus(1'b1, OFF_CTRL, ctl(1'b0, 3'h6));
    bus(1'b1, 12'h014, 32'hFFFF_FFFF);
    bus(1'b0, 12'h014, 32'h0);
    chk("unmapped", {serr, r[30:0]}, 32'h8000_0000);
    while (r[STAT_READY] !== 1'b1) bus(1'b0, OFF_STAT, 32'h0);
    chk("idle status", r & 32'h0000_071F, 32'h0);
    bus(1'b1, OFF_CRC, {16'h0, INIT, POLY});
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, OFF_CMD, {16'h0, cmds[i]});
      run(ctl(1'b0, 3'h6));
      chk("write status", s & 32'h3F, 32'h22);
      chk("command seen", 32'(sensor.last_cmd), 32'(cmds[i]));
      if (i == 0 || i == 3) begin
        run(ctl(1'b1, 3'h6));
      end
      if (i == 0) begin
        chk("stretch read", s & 32'h73F, 32'h622);
        bus(1'b0, OFF_RES, 32'h0);
        chk("result", r, {HUM, TEMP ^ cmds[i]});
      end
      if (i == 3) begin
        chk("early read", 32'(s[STAT_NACK]), 32'h1);
        repeat (MEAS / 25) @(posedge pclk);
        run(ctl(1'b1, 3'h2));
        chk("short read", s & 32'h73F, 32'h222);
        bus(1'b0, OFF_RES, 32'h0);
        chk("short result", 32'(r[15:0]), 32'(TEMP ^ cmds[i]));
      end
    end
    bus(1'b1, OFF_CMD, {16'hBEEF, 16'h6100});
    run(ctl(1'b0, 3'h6) | 32'h0000_0004);
    chk("data write status", s & 32'h3F, 32'h22);
    chk("data word seen", 32'(sensor.last_data), 32'h0000_BEEF);
    chk("command gap", 32'(sensor.gap_err), 32'h0);
    stop_test();
  end
endmodule
